/* cispct_consts.svh */
/*
  Timing counts and mode encodings for the CIS pixel conversion core.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CISPCT_CONSTS_SVH
`define CISPCT_CONSTS_SVH
`define CISPCT_CODE_W        14
`define CISPCT_HALF_W        7
`define CISPCT_LATENCY       8
`define CISPCT_OFS_W         8
`define CISPCT_MODE_W        2
`define CISPCT_MODE_DC_INT   2'h0
`define CISPCT_MODE_DC_EXT   2'h1
`define CISPCT_MODE_AC_CLAMP 2'h2
`define CISPCT_FIFO_DEPTH    8
`define CISPCT_SR_W          16
`define CISPCT_SR_MODE_LSB   8
`define CISPCT_SR_OFS_LSB    0
`endif

/* cispct_pkg.sv */
/*
  Types for the CIS pixel conversion core.
  Assumes nothing of its surroundings.
*/
package cispct_pkg;
  typedef enum logic [2:0] {
    CISPCT_ST_DC_INT = 3'h1,
    CISPCT_ST_DC_EXT = 3'h2,
    CISPCT_ST_AC     = 3'h4
  } cispct_mode_t;
endpackage : cispct_pkg

/* cispct_fifo.sv */
/*
  Small synchronous FIFO with valid/ready at both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module cispct_fifo #(
  parameter int W = 14,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          wr, rd;

  always_comb begin
    wr      = in_valid && (cnt_r != (AW+1)'(D));
    rd      = out_ready && (cnt_r != '0);
    wp_nxt  = wr ? wp_r + 1'b1 : wp_r;
    rp_nxt  = rd ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wp_r] <= in_data;
    end
  end

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
endmodule : cispct_fifo
`default_nettype wire

/* cispct_core.sv */
/*
  CIS pixel conversion timing core: serial mode load, coupling and
  reference arithmetic for digitised samples, fixed-latency pipeline,
  FIFO, and split output of each code as two halves, one per clock phase.
  Assumes the conversion clock arrives as a pin sampled with clk, and
  that the analog samples are presented already digitised in clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cispct_consts.svh"
module cispct_core import cispct_pkg::*; (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Pins from host
  input  wire logic                      conversion_clock,
  input  wire logic                      clamp_pin,
  input  wire logic                      serial_clk_pin,
  input  wire logic                      serial_data_pin,
  input  wire logic                      serial_load_strobe,
  // Digitised analog inputs
  input  wire logic [`CISPCT_CODE_W-1:0] pixel_sample,
  input  wire logic [`CISPCT_CODE_W-1:0] external_dc_reference_pin,
  // Output bus
  output logic [`CISPCT_HALF_W-1:0]      data_out,
  output logic                           tracking,
  output logic [2:0]                     mode_state
);
  localparam int CW = `CISPCT_CODE_W;
  localparam int HW = `CISPCT_HALF_W;
  localparam int LAT = `CISPCT_LATENCY;

  // Pin synchronisers
  logic [1:0] s1_r, s2_r, s3_r, s4_r, s5_r;
  logic ck_d_r, sck_d_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      s4_r <= '0;
      s5_r <= '0;
      ck_d_r <= 1'b0;
      sck_d_r <= 1'b0;
    end else begin
      s1_r <= {s1_r[0], conversion_clock};
      s2_r <= {s2_r[0], clamp_pin};
      s3_r <= {s3_r[0], serial_clk_pin};
      s4_r <= {s4_r[0], serial_data_pin};
      s5_r <= {s5_r[0], serial_load_strobe};
      ck_d_r <= s1_r[1];
      sck_d_r <= s3_r[1];
    end
  end
  wire logic ck_s = s1_r[1];
  wire logic fall = ck_d_r && !ck_s;
  wire logic rise = !ck_d_r && ck_s;
  wire logic sck_rise = !sck_d_r && s3_r[1];
  wire logic clamp_s = s2_r[1];
  wire logic load_s = s5_r[1];

  // Serial control shift register
  logic [`CISPCT_SR_W-1:0] sr_r, sr_nxt;
  logic [`CISPCT_MODE_W-1:0] mode_r, mode_nxt;
  logic [`CISPCT_OFS_W-1:0] ofs_r, ofs_nxt;
  logic load_d_r;
  always_comb begin
    sr_nxt = sr_r;
    mode_nxt = mode_r;
    ofs_nxt = ofs_r;
    if (!load_s && sck_rise) begin
      sr_nxt = {sr_r[`CISPCT_SR_W-2:0], s4_r[1]};
    end
    if (load_s && !load_d_r) begin
      mode_nxt = sr_r[`CISPCT_SR_MODE_LSB +: `CISPCT_MODE_W];
      ofs_nxt = sr_r[`CISPCT_SR_OFS_LSB +: `CISPCT_OFS_W];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_r <= '0;
      mode_r <= `CISPCT_MODE_DC_INT;
      ofs_r <= '0;
      load_d_r <= 1'b0;
    end else begin
      sr_r <= sr_nxt;
      mode_r <= mode_nxt;
      ofs_r <= ofs_nxt;
      load_d_r <= load_s;
    end
  end

  cispct_mode_t st;
  always_comb begin
    case (mode_r)
      `CISPCT_MODE_DC_EXT:   st = CISPCT_ST_DC_EXT;
      `CISPCT_MODE_AC_CLAMP: st = CISPCT_ST_AC;
      default:               st = CISPCT_ST_DC_INT;
    endcase
  end

  // Sample path
  logic [CW-1:0] black_r, black_nxt, code_r, code_nxt;
  // Code register and FIFO make up the other two falls of latency
  logic [CW-1:0] pipe_r [LAT-2];
  logic [CW:0] diff;
  logic [CW-1:0] ref_v;
  always_comb begin
    black_nxt = black_r;
    ref_v = '0;
    case (st)
      CISPCT_ST_DC_INT: ref_v = '0;
      CISPCT_ST_DC_EXT: ref_v = external_dc_reference_pin;
      CISPCT_ST_AC: begin
        ref_v = black_r;
        if (clamp_s && fall) begin
          black_nxt = pixel_sample;
        end
      end
      default: ref_v = '0;
    endcase
    diff = {1'b0, pixel_sample} - {1'b0, ref_v}
           + {{(CW+1-`CISPCT_OFS_W){1'b0}}, ofs_r};
    // Saturate: negative clips to zero, overflow to full scale
    if ({1'b0, pixel_sample} + {{(CW+1-`CISPCT_OFS_W){1'b0}}, ofs_r} < {1'b0, ref_v}) begin
      code_nxt = '0;
    end else if (diff[CW]) begin
      code_nxt = '1;
    end else begin
      code_nxt = diff[CW-1:0];
    end
  end

  // sample at falling edge; fixed latency shift
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      black_r <= '0;
      code_r <= '0;
      for (int i = 0; i < LAT-2; i++) pipe_r[i] <= '0;
    end else begin
      black_r <= black_nxt;
      if (fall) begin
        code_r <= code_nxt;
        pipe_r[0] <= code_r;
        for (int i = 1; i < LAT-2; i++) pipe_r[i] <= pipe_r[i-1];
      end
    end
  end

  // FIFO between pipeline and output halves
  logic f_ready, f_valid;
  logic [CW-1:0] f_data;
  logic pop;
  cispct_fifo #(.W(CW), .D(`CISPCT_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fall && f_ready),
    .in_ready  (f_ready),
    .in_data   (pipe_r[LAT-3]),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_data)
  );

  // Output halves
  logic [CW-1:0] hold_r, hold_nxt;
  logic [HW-1:0] out_r, out_nxt;
  logic trk_r, trk_nxt;
  always_comb begin
    hold_nxt = hold_r;
    out_nxt = out_r;
    pop = 1'b0;
    trk_nxt = trk_r;
    if (fall) begin
      pop = f_valid;
      hold_nxt = f_valid ? f_data : hold_r;
      out_nxt = f_valid ? f_data[CW-1 -: HW] : hold_r[CW-1 -: HW];
      trk_nxt = 1'b0;
    end
    // lower half after rise, track while high
    if (rise) begin
      out_nxt = hold_r[HW-1:0];
      trk_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= '0;
      out_r <= '0;
      trk_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      out_r <= out_nxt;
      trk_r <= trk_nxt;
    end
  end

  logic [2:0] st_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st_r <= 3'h1;
    else st_r <= st;
  end

  assign data_out = out_r;
  assign tracking = trk_r;
  assign mode_state = st_r;

  a_track_phase: assert property (@(posedge clk) disable iff (!rst_n)
    rise |=> tracking) else $error("track not set after rise");
  a_hold_phase: assert property (@(posedge clk) disable iff (!rst_n)
    fall |=> !tracking) else $error("hold not set after fall");
  a_mode_load: assert property (@(posedge clk) disable iff (!rst_n)
    (load_s && !load_d_r) |=> mode_r == $past(sr_r[`CISPCT_SR_MODE_LSB +: `CISPCT_MODE_W]))
    else $error("mode not loaded");
  a_dc_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (fall && st == CISPCT_ST_DC_INT && pixel_sample == '0 && ofs_r == '0) |=> code_r == '0)
    else $error("zero input not zero code");
  a_black_store: assert property (@(posedge clk) disable iff (!rst_n)
    (fall && clamp_s && st == CISPCT_ST_AC) |=> black_r == $past(pixel_sample))
    else $error("black level not stored");
  a_clamp_unused: assert property (@(posedge clk) disable iff (!rst_n)
    (st != CISPCT_ST_AC) |=> black_r == $past(black_r)) else $error("clamp used in DC");
  a_lsb_half: assert property (@(posedge clk) disable iff (!rst_n)
    rise |=> data_out == $past(hold_r[HW-1:0])) else $error("lower half wrong");
  a_pipe_step: assert property (@(posedge clk) disable iff (!rst_n)
    fall |=> pipe_r[1] == $past(pipe_r[0])) else $error("pipeline stalled");
  a_msb_half: assert property (@(posedge clk) disable iff (!rst_n)
    (fall && f_valid) |=> data_out == $past(f_data[CW-1 -: HW])) else $error("upper half wrong");
endmodule : cispct_core
`default_nettype wire

/* cispct_host.sv */
/*
  Host and sensor-side model: conversion clock, clamp and serial load.
  Assumes its tasks are called from the bench, just after a clk edge.
*/
`timescale 1ns/10ps
`default_nettype none
module cispct_host (
  // Clock
  input  wire logic clk,
  // Pins to core
  output logic      conversion_clock,
  output logic      clamp_pin,
  output logic      serial_clk_pin,
  output logic      serial_data_pin,
  output logic      serial_load_strobe
);
  localparam int HALF = 6;
  initial begin
    // Idle low matches the edge detector after reset: no false rise
    conversion_clock = 1'b0;
    clamp_pin = 1'b0;
    serial_clk_pin = 1'b0;
    serial_data_pin = 1'b0;
    serial_load_strobe = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic phase(input logic lvl, input logic clmp);
    conversion_clock = lvl;
    clamp_pin = clmp;
    tick(HALF);
  endtask : phase
  task automatic load(input logic [15:0] w);
    serial_load_strobe = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_data_pin = w[i];
      tick(4);
      serial_clk_pin = 1'b1;
      tick(4);
      serial_clk_pin = 1'b0;
    end
    tick(4);
    serial_load_strobe = 1'b1;
    // Released line must not keep the last bit
    serial_data_pin = ~w[0];
    tick(6);
  endtask : load
endmodule : cispct_host
`default_nettype wire

/* cis_pixel_conversion_timing_tb.sv */
/*
  Self-checking bench for the CIS conversion core.
  Assumes the host model and the design files compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cispct_consts.svh"
module cis_pixel_conversion_timing_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [13:0] smp = '0;
  logic [13:0] ext = '0;
  wire logic [6:0] dout;
  wire logic [2:0] mst;
  wire logic   trk, cck, clp, sck, sda, sld;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  logic [31:0] rnd = 32'h4544;
  logic [7:0]  ofs = '0;
  logic [1:0]  md = '0;
  logic [13:0] blk = '0;
  logic [14:0] q[$];
  logic [14:0] pend = '0;
  logic [6:0]  up = '0;
  logic        have = 1'b0;

  always #2.5 clk = ~clk;

  cispct_core cispct_core_i (.clk(clk), .rst_n(rst_n), .conversion_clock(cck),
    .clamp_pin(clp), .serial_clk_pin(sck), .serial_data_pin(sda),
    .serial_load_strobe(sld), .pixel_sample(smp), .external_dc_reference_pin(ext),
    .data_out(dout), .tracking(trk), .mode_state(mst));
  cispct_host cispct_host_i (.clk(clk), .conversion_clock(cck), .clamp_pin(clp),
    .serial_clk_pin(sck), .serial_data_pin(sda), .serial_load_strobe(sld));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Saturating code for the mode in force at sampling
  function automatic logic [13:0] exp_code(input logic [1:0] m,
    input logic [13:0] s, input logic [13:0] e, input logic [13:0] b,
    input logic [7:0] o);
    int v;
    v = int'(s) + int'(o);
    if (m == `CISPCT_MODE_DC_EXT) v -= int'(e);
    if (m == `CISPCT_MODE_AC_CLAMP) v -= int'(b);
    return v < 0 ? 14'h0 : (v > 16383 ? 14'h3fff : 14'(v));
  endfunction : exp_code

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] ex);
    tests_run++;
    if (seen !== ex) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  // Lower half of the previous code arrives in this high phase
  task automatic pix(input logic c, input logic [13:0] s, input logic [13:0] e);
    smp = s;
    ext = e;
    cispct_host_i.phase(1'b1, c);
    check("tracking_hi", trk, 1'b1);
    if (have) check("code", {up, dout}, pend[13:0]);
    if (c && md == `CISPCT_MODE_AC_CLAMP) blk = s;
    cispct_host_i.phase(1'b0, c);
    check("tracking_lo", trk, 1'b0);
    up = dout;
    q.push_back({!(c && md == `CISPCT_MODE_AC_CLAMP), exp_code(md, s, e, blk, ofs)});
    have = 1'b0;
    if (q.size() > `CISPCT_LATENCY) begin
      pend = q.pop_front();
      have = pend[14];
    end
  endtask : pix

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    check("mode_rst", mst, 3'h1);
    // Modes 0..3 then 0 again; first pass is zero input, zero offset
    for (int t = 0; t < 5; t++) begin
      rnd = lfsr(rnd);
      md = t[1:0];
      ofs = (t == 0) ? 8'h0 : rnd[7:0];
      cispct_host_i.load({6'h0, md, ofs});
      check("mode", mst, md == 2'h1 ? 3'h2 : (md == 2'h2 ? 3'h4 : 3'h1));
      for (int p = 0; p < 24; p++) begin
        rnd = lfsr(rnd);
        pix(md == 2'h2 ? p < 2 : rnd[20], t == 0 ? 14'h0 : rnd[13:0],
          {2'h0, rnd[27:16]});
      end
      $display("test %0d mode %0d done", t, md);
    end
    finish_test();
  end
endmodule : cis_pixel_conversion_timing_tb
`default_nettype wire
